// ---- tb/sesfe_mst.sv ----
// SPI bus master model driving the front end's pins
`timescale 1ns/100ps
module sesfe_mst (
  // Clock
  input  wire logic ref_clk,
  // SPI pins
  output      logic spi_clk,
  output      logic spi_cs_n,
  output      logic spi_mosi,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe
);
  logic last_q;
  logic miso;
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    last_q   = 1'b0;
  end
  always @(posedge ref_clk) if (spi_miso_oe) last_q <= spi_miso_o;
  // Released line shows the inverse of the last driven bit
  assign miso = spi_miso_oe ? spi_miso_o : ~last_q;
  // Half of the 160 ns link period
  task automatic half();
    repeat (16) @(negedge ref_clk);
  endtask
  // Only this device is ever selected
  task automatic start(input logic mode3);
    spi_cs_n = 1'b0;
    // Mode 3 clock rises with the select fall, never before it
    if (mode3) spi_clk = 1'b1;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      spi_clk  = 1'b0;
      spi_mosi = tx[7-i];
      half();
      spi_clk = 1'b1;
      rx      = {rx[6:0], miso};
      half();
    end
  endtask
  // Clock down before select rises
  task automatic stop();
    spi_clk = 1'b0;
    half();
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    half();
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the SPI front end
`timescale 1ns/100ps
module tb_top
  import sesfe_pkg::*;
;
  typedef struct {
    logic       mode3;
    logic [7:0] b0;
    logic [7:0] b1;
    logic       txv;
    logic [7:0] txd;
    logic [7:0] exp_rd;
  } sesfe_row_t;
  logic ref_clk, resetn, spi_clk, spi_cs_n, spi_mosi, miso_o, miso_oe;
  logic rx_valid, rx_ready, rx_overrun_q, tx_valid, tx_taken_q;
  logic frame_ok_q, frame_bad_q, status_wr, lock, bph, bpl;
  logic [RXW_W-1:0]  rx_word;
  logic [BYTE_W-1:0] tx_data, rd;
  logic [2:0]        status_wr_data;
  logic [8:0]        rxq[$];
  int                err_count, n_checks, ok_cnt, bad_cnt, taken_cnt;
  int                ok0, tk0, bad0;
  sesfe_row_t        rows [4];
  sesfe_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(miso_o),
    .spi_miso_oe(miso_oe), .rx_valid(rx_valid), .rx_word(rx_word),
    .rx_ready(rx_ready), .rx_overrun_q(rx_overrun_q), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_taken_q(tx_taken_q), .frame_ok_q(frame_ok_q),
    .frame_bad_q(frame_bad_q), .status_wr(status_wr),
    .status_wr_data(status_wr_data), .status_write_lock_q(lock),
    .block_protect_high_q(bph), .block_protect_low_q(bpl));
  sesfe_mst mst_u (.ref_clk(ref_clk), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso_o(miso_o),
    .spi_miso_oe(miso_oe));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_word);
    if (frame_ok_q === 1'b1) ok_cnt++;
    if (frame_bad_q === 1'b1) bad_cnt++;
    if (tx_taken_q === 1'b1) taken_cnt++;
  end
  task automatic chk(input string nm, input logic [8:0] e,
                     input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    resetn = 1'b0; rx_ready = 1'b1; tx_valid = 1'b0; tx_data = 8'h00;
    status_wr = 1'b0; status_wr_data = 3'h0;
    rows[0] = '{1'b0, 8'h03, 8'ha5, 1'b0, 8'h00, 8'hff};
    rows[1] = '{1'b1, 8'h05, 8'h5a, 1'b1, 8'h81, 8'h81};
    rows[2] = '{1'b0, 8'hff, 8'h00, 1'b1, 8'h00, 8'h00};
    rows[3] = '{1'b1, 8'h80, 8'h01, 1'b0, 8'h7e, 8'hff};
    wait_n(2);
    resetn = 1'b1;
    wait_n(4);
    chk("prot_bits", 9'h000, {6'h00, lock, bph, bpl});
    chk_b("miso_oe", 1'b0, miso_oe);
    chk_b("miso_o", 1'b1, miso_o);
    chk_b("rx_valid", 1'b0, rx_valid);
    foreach (rows[i]) begin
      tx_valid = rows[i].txv;
      tx_data  = rows[i].txd;
      rxq.delete();
      ok0 = ok_cnt;
      tk0 = taken_cnt;
      mst_u.start(rows[i].mode3);
      mst_u.xfer(rows[i].b0, 8, rd);
      mst_u.xfer(rows[i].b1, 8, rd);
      chk_b("miso_oe", 1'b1, miso_oe);
      mst_u.stop();
      wait_n(4);
      chk_b("miso_oe", 1'b0, miso_oe);
      chk("read", rows[i].exp_rd, rd);
      chk_b("tx_taken", rows[i].txv, taken_cnt != tk0);
      chk("rx_cnt", 9'h002, 9'(rxq.size()));
      chk("rx_first", {1'b1, rows[i].b0}, rxq[0]);
      chk("rx_second", {1'b0, rows[i].b1}, rxq[1]);
      chk_b("frame_ok", 1'b1, ok_cnt == ok0 + 1);
      $display("Test row %0d done", i);
    end
    // Partial byte, then a clean frame restarts framing
    rxq.delete();
    bad0 = bad_cnt;
    mst_u.start(1'b0);
    mst_u.xfer(8'hc3, 4, rd);
    mst_u.stop();
    wait_n(4);
    chk_b("frame_bad", 1'b1, bad_cnt == bad0 + 1);
    chk("rx_cnt", 9'h000, 9'(rxq.size()));
    mst_u.start(1'b0);
    mst_u.xfer(8'h3c, 8, rd);
    mst_u.stop();
    wait_n(4);
    chk("rx_first", 9'h13c, rxq[0]);
    $display("Test partial byte done");
    // Stalled receiver: third byte lost, two kept
    rxq.delete();
    rx_ready = 1'b0;
    mst_u.start(1'b1);
    mst_u.xfer(8'h11, 8, rd);
    mst_u.xfer(8'h22, 8, rd);
    mst_u.xfer(8'h33, 8, rd);
    mst_u.stop();
    chk_b("overrun", 1'b1, rx_overrun_q);
    chk_b("rx_valid", 1'b1, rx_valid);
    rx_ready = 1'b1;
    wait_n(6);
    chk("rx_cnt", 9'h002, 9'(rxq.size()));
    chk("rx_first", 9'h111, rxq[0]);
    chk("rx_second", 9'h022, rxq[1]);
    mst_u.start(1'b0);
    wait_n(8);
    chk_b("overrun", 1'b0, rx_overrun_q);
    mst_u.stop();
    $display("Test overrun done");
    // Protection bits load, then reset in mid-run
    status_wr_data = 3'h5;
    status_wr = 1'b1;
    wait_n(1);
    status_wr = 1'b0;
    wait_n(1);
    chk("prot_bits", 9'h005, {6'h00, lock, bph, bpl});
    status_wr_data = 3'h2;
    status_wr = 1'b1;
    wait_n(1);
    status_wr = 1'b0;
    wait_n(1);
    chk("prot_bits", 9'h002, {6'h00, lock, bph, bpl});
    resetn = 1'b0;
    wait_n(2);
    resetn = 1'b1;
    wait_n(2);
    chk("prot_bits", 9'h000, {6'h00, lock, bph, bpl});
    chk_b("miso_oe", 1'b0, miso_oe);
    chk_b("miso_o", 1'b1, miso_o);
    chk_b("overrun", 1'b0, rx_overrun_q);
    chk_b("rx_valid", 1'b0, rx_valid);
    $display("Test protection bits done");
    results();
  end
endmodule

// ---- verilog/sesfe_buf2.sv ----
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/100ps
module sesfe_buf2 #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  // Drain side
  output      logic             out_valid,
  output      logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic             head_v_q;
  logic             tail_v_q;
  logic             push;
  logic             pop;

  assign in_ready  = ~tail_v_q;
  assign out_valid = head_v_q;
  assign out_data  = head_q;
  assign push      = in_valid & ~tail_v_q;
  assign pop       = head_v_q & out_ready;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      head_q   <= '0;
      tail_q   <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end else if (pop && tail_v_q) begin
      head_q   <= tail_q;
      tail_v_q <= 1'b0;
    end else if (pop) begin
      head_v_q <= push;
      head_q   <= in_data;
    end else if (push && !head_v_q) begin
      head_v_q <= 1'b1;
      head_q   <= in_data;
    end else if (push) begin
      tail_v_q <= 1'b1;
      tail_q   <= in_data;
    end
  end

endmodule

// ---- verilog/sesfe_pkg.sv ----
// Shared constants for the serial EEPROM SPI front end
package sesfe_pkg;

  // Byte framing
  localparam int          BYTE_W      = 8;
  localparam int          BIT_CNT_W   = 3;
  localparam int          BYTE_CNT_W  = 4;
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BIT_STEP    = 3'h1;
  localparam logic [3:0]  BYTE_NONE   = 4'h0;
  localparam logic [3:0]  BYTE_STEP   = 4'h1;
  localparam logic [3:0]  BYTE_SAT    = 4'hf;

  // Delivery state
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic        LOCK_RST    = 1'b0;
  localparam logic        BP_HIGH_RST = 1'b0;
  localparam logic        BP_LOW_RST  = 1'b0;

  // Status write data field positions
  localparam int          ST_LOCK     = 2;
  localparam int          ST_BP_HIGH  = 1;
  localparam int          ST_BP_LOW   = 0;

  // Received word: first-byte flag above the data byte
  localparam int          RXW_W       = 9;
  localparam int          RXW_FIRST   = 8;

endpackage

// ---- verilog/sesfe_top.sv ----
// SPI slave front end: bit framing, shifting and delivery state
// Functional notes
// - Bytes sent with no array data available read as all ones (FFh).
// - Status write lock and both block protect bits reset to zero.
// - Incoming instruction, address and data bytes arrive MSB first.
// - First input bit is the first clock rise after select falls.
// - Every returned byte leaves on the output MSB first.
// - First output bit is driven on the first fall after the instruction.
// - Output is released (not driven) whenever the device is deselected.
// - Inputs captured on rising edges, outputs change on falling edges.
// - Select low starts a transaction; select high ends it at any time.
// - Write frames count only if select rises on a byte boundary.
`timescale 1ns/100ps
module sesfe_top
  import sesfe_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // SPI pins
  input  wire logic               spi_clk,
  input  wire logic               spi_cs_n,
  input  wire logic               spi_mosi,
  output      logic               spi_miso_o,
  output      logic               spi_miso_oe,
  // Received bytes
  output      logic               rx_valid,
  output      logic [RXW_W-1:0]   rx_word,
  input  wire logic               rx_ready,
  output      logic               rx_overrun_q,
  // Bytes to return
  input  wire logic               tx_valid,
  input  wire logic [BYTE_W-1:0]  tx_data,
  output      logic               tx_taken_q,
  // Frame end report
  output      logic               frame_ok_q,
  output      logic               frame_bad_q,
  // Protection bits
  input  wire logic               status_wr,
  input  wire logic [2:0]         status_wr_data,
  output      logic               status_write_lock_q,
  output      logic               block_protect_high_q,
  output      logic               block_protect_low_q
);

  logic [2:0]            clk_sync_q;
  logic [2:0]            cs_sync_q;
  logic [1:0]            mosi_sync_q;
  logic                  sel;
  logic                  rise_ev;
  logic                  fall_ev;
  logic                  cs_rise;
  logic                  cs_fall;
  logic [BIT_CNT_W-1:0]  bit_cnt_q;
  logic [BYTE_CNT_W-1:0] byte_cnt_q;
  logic [BYTE_W-1:0]     rx_sh_q;
  logic                  push_q;
  logic [RXW_W-1:0]      push_word_q;
  logic                  buf_in_ready;
  logic [BYTE_W-1:0]     tx_sh_q;
  logic                  load_ev;
  logic [BYTE_W-1:0]     load_byte;
  logic                  byte_done;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      clk_sync_q  <= '0;
      cs_sync_q   <= '1;
      mosi_sync_q <= '0;
    end else begin
      clk_sync_q  <= {clk_sync_q[1:0], spi_clk};
      cs_sync_q   <= {cs_sync_q[1:0], spi_cs_n};
      mosi_sync_q <= {mosi_sync_q[0], spi_mosi};
    end
  end

  // Edges seen only while selected
  // Select stands two stages; masks an edge arriving with it
  assign sel     = ~cs_sync_q[1] & ~cs_sync_q[2];
  assign rise_ev = sel & clk_sync_q[1] & ~clk_sync_q[2];
  assign fall_ev = sel & ~clk_sync_q[1] & clk_sync_q[2];
  assign cs_fall = ~cs_sync_q[1] & cs_sync_q[2];
  assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];

  assign byte_done = rise_ev && (bit_cnt_q == BIT_LAST);
  assign load_ev   = fall_ev && (bit_cnt_q == BIT_FIRST) &&
                     (byte_cnt_q != BYTE_NONE);
  assign load_byte = tx_valid ? tx_data : ERASED_BYTE;

  // Bit and byte counters
  always_ff @(posedge ref_clk) begin
    if (!resetn || !sel) begin
      bit_cnt_q  <= BIT_FIRST;
      byte_cnt_q <= BYTE_NONE;
    end else if (rise_ev) begin
      bit_cnt_q <= bit_cnt_q + BIT_STEP;
      if (byte_done && byte_cnt_q != BYTE_SAT) begin
        byte_cnt_q <= byte_cnt_q + BYTE_STEP;
      end
    end
  end

  // Input shifter, MSB first
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rx_sh_q <= '0;
    end else if (rise_ev) begin
      rx_sh_q <= {rx_sh_q[BYTE_W-2:0], mosi_sync_q[1]};
    end
  end

  // Completed byte into the buffer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      push_q      <= 1'b0;
      push_word_q <= '0;
    end else begin
      push_q <= byte_done;
      if (byte_done) begin
        push_word_q <= {byte_cnt_q == BYTE_NONE,
                        rx_sh_q[BYTE_W-2:0], mosi_sync_q[1]};
      end
    end
  end

  // Overrun when buffer full; set wins over frame-start clear
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rx_overrun_q <= 1'b0;
    end else if (push_q && !buf_in_ready) begin
      rx_overrun_q <= 1'b1;
    end else if (cs_fall) begin
      rx_overrun_q <= 1'b0;
    end
  end

  sesfe_buf2 #(
    .WIDTH     (RXW_W)
  ) u_rx_buf (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (push_q),
    .in_data   (push_word_q),
    .in_ready  (buf_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_word),
    .out_ready (rx_ready)
  );

  // Output shifter, changes on falling edges only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tx_sh_q    <= ERASED_BYTE;
      spi_miso_o <= 1'b1;
      tx_taken_q <= 1'b0;
    end else begin
      tx_taken_q <= load_ev && tx_valid;
      if (load_ev) begin
        tx_sh_q    <= load_byte;
        spi_miso_o <= load_byte[BYTE_W-1];
      end else if (fall_ev) begin
        tx_sh_q    <= {tx_sh_q[BYTE_W-2:0], 1'b1};
        spi_miso_o <= tx_sh_q[BYTE_W-2];
      end
    end
  end

  // Output enable from first load until deselect
  always_ff @(posedge ref_clk) begin
    if (!resetn || !sel) begin
      spi_miso_oe <= 1'b0;
    end else if (load_ev) begin
      spi_miso_oe <= 1'b1;
    end
  end

  // Frame end report on select rise
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      frame_ok_q  <= 1'b0;
      frame_bad_q <= 1'b0;
    end else begin
      frame_ok_q  <= cs_rise && (bit_cnt_q == BIT_FIRST) &&
                     (byte_cnt_q != BYTE_NONE);
      frame_bad_q <= cs_rise && ((bit_cnt_q != BIT_FIRST) ||
                     (byte_cnt_q == BYTE_NONE));
    end
  end

  // Protection bits
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status_write_lock_q  <= LOCK_RST;
      block_protect_high_q <= BP_HIGH_RST;
      block_protect_low_q  <= BP_LOW_RST;
    end else if (status_wr) begin
      status_write_lock_q  <= status_wr_data[ST_LOCK];
      block_protect_high_q <= status_wr_data[ST_BP_HIGH];
      block_protect_low_q  <= status_wr_data[ST_BP_LOW];
    end
  end

  // Framing, shifting and delivery state checks
  erased_fill_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) load_ev && !tx_valid |=> tx_sh_q == ERASED_BYTE)
    else $error("empty source did not give erased byte");

  status_reset_a: assert property (@(posedge ref_clk)
    !resetn |=> !status_write_lock_q && !block_protect_high_q &&
                !block_protect_low_q)
    else $error("protection bits not zero after reset");

  in_msb_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    byte_done |=> push_q &&
                  push_word_q[BYTE_W-1] == $past(rx_sh_q[BYTE_W-2]))
    else $error("first received bit not in byte MSB");

  first_bit_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    cs_fall |=> bit_cnt_q == BIT_FIRST && byte_cnt_q == BYTE_NONE)
    else $error("framing not restarted at select fall");

  out_msb_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    load_ev |=> spi_miso_o == $past(load_byte[BYTE_W-1]))
    else $error("returned byte not started with MSB");

  first_out_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) load_ev |=> spi_miso_oe)
    else $error("output not driven after instruction");

  hiz_desel_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) cs_sync_q[1] |=> !spi_miso_oe)
    else $error("output driven while deselected");

  fall_only_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !fall_ev && !$past(fall_ev) |-> $stable(spi_miso_o))
    else $error("output changed away from falling edge");

  rise_capture_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    rise_ev |=> bit_cnt_q == $past(bit_cnt_q) + BIT_STEP)
    else $error("rising edge did not advance bit count");

  frame_end_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) cs_rise |=> frame_ok_q ^ frame_bad_q)
    else $error("select rise gave no single frame report");

  commit_align_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) frame_ok_q |-> $past(bit_cnt_q) == BIT_FIRST)
    else $error("frame accepted off a byte boundary");

  deselect_idle_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    cs_sync_q[1] && cs_sync_q[2] |-> bit_cnt_q == BIT_FIRST && !rise_ev)
    else $error("counters active while deselected");

  sel_guard_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) cs_fall |-> !rise_ev && !fall_ev)
    else $error("clock edge taken with select fall");

  desel_clear_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    !sel |=> bit_cnt_q == BIT_FIRST && byte_cnt_q == BYTE_NONE)
    else $error("counters not cleared while deselected");

  no_early_out_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    fall_ev && byte_cnt_q == BYTE_NONE |=> !spi_miso_oe)
    else $error("output driven before instruction done");

  oe_hold_a: assert property (@(posedge ref_clk)
    disable iff (!resetn) spi_miso_oe && sel |=> spi_miso_oe)
    else $error("output released while selected");

  shift_out_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    fall_ev && !load_ev |=> spi_miso_o == $past(tx_sh_q[BYTE_W-2]))
    else $error("returned byte not shifted MSB first");

  taken_pulse_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    tx_taken_q |-> $past(load_ev) && $past(tx_valid))
    else $error("byte taken without a load");

  status_load_a: assert property (@(posedge ref_clk)
    disable iff (!resetn)
    status_wr |=> status_write_lock_q == $past(status_wr_data[ST_LOCK]) &&
                  block_protect_high_q == $past(status_wr_data[ST_BP_HIGH]) &&
                  block_protect_low_q == $past(status_wr_data[ST_BP_LOW]))
    else $error("protection bits not loaded");

  // Main scenarios
  read_out_c: cover property (@(posedge ref_clk) load_ev && tx_valid);
  erased_out_c: cover property (@(posedge ref_clk) load_ev && !tx_valid);
  frame_ok_c: cover property (@(posedge ref_clk) frame_ok_q);
  frame_bad_c: cover property (@(posedge ref_clk) frame_bad_q);
  overrun_c: cover property (@(posedge ref_clk) $rose(rx_overrun_q));

endmodule
